/* verilog/flash_interrupt_security_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Code 0x01 verifies all EEPROM and flash blocks; 0x02 verifies EEPROM only.
// - Two interrupt sources: command complete and ECC fault on flash read.
// - Command interrupt when complete flag and its enable are both set.
// - Error interrupt on double fault with enable, or single fault with enable.
// - Successful key verify with keys enabled forces security state to 10.
// - After an illegal key, key verify is refused until next reset.
// - Key verify never alters the stored security byte, only the live state.
// - Key verify leaves stored keys and protection register untouched.
// - Once unsecured, security sector and key locations may be rewritten.
// - Special-mode verify-all finding everything erased unsecures and enables debug.
// - Twenty byte registers decoded from index 0x00 through 0x13.
// - While complete flag is 0, parameter writes are ignored, no new launch.
// - Divider write sets loaded flag; unloaded divider blocks program/erase with error.
module flash_interrupt_security_ctrl
  import flash_ctrl_pkg::*;
(
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  input wire logic [7:0] nv_security, // Stored security byte from array
  input wire logic special_mode, // Special single-chip mode
  input wire logic cmd_done, // Array finished running command
  input wire logic verify_erased, // Verify found blocks erased
  input wire logic key_match, // Backdoor keys matched
  input wire logic [1:0] array_mgstat, // Array status on completion
  input wire logic read_valid, // Array read strobe
  input wire logic ecc_single, // Single bit fault on read
  input wire logic ecc_double, // Double bit fault on read
  output logic cmd_start, // One-cycle launch to array
  output logic [7:0][15:0] command_parameters, // Parameter words
  output logic verify_all_blocks, // Scope: all blocks
  output logic verify_eeprom_only, // Scope: EEPROM only
  output logic [7:0] program_protection, // Protection settings
  output logic [5:0] clock_divider, // Divider field
  output logic unsecured, // Live security is unsecure
  output logic debug_enabled, // All debug-port commands allowed
  output logic security_area_open, // Security sector and keys writable
  output logic cmd_irq, // Command interrupt request
  output logic err_irq // Error interrupt request
);

  // ==========================================================
  // Command classification
  function automatic logic is_prog_erase(input logic [7:0] code);
    is_prog_erase = (code >= CMD_PROG_FIRST) && (code <= CMD_UNSECURE);
  endfunction : is_prog_erase

  function automatic logic is_verify_all(input logic [7:0] code);
    is_verify_all = (code == CMD_VERIFY_ALL);
  endfunction : is_verify_all

  ctrl_state_t r;
  ctrl_state_t next_r;
  logic [7:0] code;
  logic [7:0] wbyte;
  logic wr;
  logic [7:0] rd_value;

  assign code = r.params[0][15:8];
  assign wbyte = hwdata[7:0];
  // Write applied in the wait cycle of the data phase
  assign wr = (r.bus == BUS_WAIT) && r.bus_write;

  // ==========================================================
  // Read multiplexer; unimplemented indices read zero
  always_comb begin
    rd_value = 8'h00;
    case (r.bus_index)
      IDX_CLOCK_DIVIDER: rd_value = {r.div_loaded, r.div_lock, r.divider};
      IDX_SECURITY_CONFIG: rd_value = {r.key_enable, r.sec_reserved, r.security_state};
      IDX_COMMAND_PARAM_INDEX: rd_value = {5'h00, r.param_index};
      IDX_MODULE_CONFIG: rd_value = {r.done_irq_en, 2'h0, r.ignsf, 2'h0, r.fdfd, r.fsfd};
      IDX_ERROR_INTERRUPT_CONFIG: rd_value = {6'h00, r.double_fault_irq_enable, r.single_fault_irq_enable};
      IDX_COMMAND_STATUS: rd_value = {r.done_flag, 1'b0, r.access_err, r.fpviol, 2'h0, r.mgstat};
      IDX_ERROR_STATUS: rd_value = {6'h00, r.double_fault_flag, r.single_fault_flag};
      IDX_PROGRAM_PROTECTION: rd_value = r.protection;
      IDX_PARAM_HIGH: rd_value = r.params[r.param_index][15:8];
      IDX_PARAM_LOW: rd_value = r.params[r.param_index][7:0];
      default: rd_value = 8'h00;
    endcase
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.cmd_start = 1'b0;

    // Bus slave: one wait state so reads see writes just made
    case (r.bus)
      BUS_IDLE, BUS_DONE: begin
        if (hsel && htrans[1] && hready) begin
          next_r.bus = BUS_WAIT;
          next_r.bus_write = hwrite;
          // Beyond the twenty registers the index reads zero
          next_r.bus_index = (haddr[31:2] <= {25'h0, IDX_LAST}) ? haddr[6:2] : 5'h1F;
        end else begin
          next_r.bus = BUS_IDLE;
        end
      end
      BUS_WAIT: begin
        next_r.bus = BUS_DONE;
        next_r.rdata = rd_value;
      end
      default: next_r.bus = BUS_IDLE;
    endcase

    // Live security captured from the array once after reset
    if (!r.sec_loaded) begin
      next_r.sec_loaded = 1'b1;
      next_r.key_enable = nv_security[7:6];
      next_r.sec_reserved = nv_security[5:2];
      next_r.security_state = nv_security[1:0];
    end

    // Register writes; divider, parameter index, protection and parameters held steady while a command runs
    if (wr) begin
      case (r.bus_index)
        IDX_CLOCK_DIVIDER: begin
          if (!r.div_lock && r.done_flag) begin
            next_r.divider = wbyte[5:0];
            next_r.div_lock = wbyte[DIV_LOCK_BIT];
            next_r.div_loaded = 1'b1;
          end
        end
        IDX_COMMAND_PARAM_INDEX: begin
          if (r.done_flag) next_r.param_index = wbyte[2:0];
        end
        IDX_MODULE_CONFIG: begin
          next_r.done_irq_en = wbyte[DONE_IRQ_EN_BIT];
          next_r.ignsf = wbyte[IGNSF_BIT];
          next_r.fdfd = wbyte[FDFD_BIT];
          next_r.fsfd = wbyte[FSFD_BIT];
        end
        IDX_ERROR_INTERRUPT_CONFIG: begin
          next_r.double_fault_irq_enable = wbyte[DOUBLE_BIT];
          next_r.single_fault_irq_enable = wbyte[SINGLE_BIT];
        end
        IDX_ERROR_STATUS: begin
          if (wbyte[DOUBLE_BIT]) next_r.double_fault_flag = 1'b0;
          if (wbyte[SINGLE_BIT]) next_r.single_fault_flag = 1'b0;
        end
        IDX_PROGRAM_PROTECTION: begin
          if (r.done_flag) next_r.protection = wbyte;
        end
        IDX_PARAM_HIGH: begin
          if (r.done_flag) next_r.params[r.param_index][15:8] = wbyte;
        end
        IDX_PARAM_LOW: begin
          if (r.done_flag) next_r.params[r.param_index][7:0] = wbyte;
        end
        IDX_COMMAND_STATUS: begin
          if (wbyte[ACCESS_ERR_BIT]) next_r.access_err = 1'b0;
          if (wbyte[FPVIOL_BIT]) next_r.fpviol = 1'b0;
          // Launch only from idle with both error flags already clear
          if (wbyte[DONE_FLAG_BIT] && r.done_flag && !r.access_err && !r.fpviol) begin
            if (is_prog_erase(code) && !r.div_loaded) begin
              next_r.access_err = 1'b1;
            end else if (code == CMD_KEY_VERIFY &&
                         (r.key_locked || r.key_enable != KEY_ACCESS_ON)) begin
              next_r.access_err = 1'b1;
            end else begin
              next_r.done_flag = 1'b0;
              next_r.cmd_start = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    // Completion from the array; protection and stored bytes untouched
    if (!r.done_flag && cmd_done) begin
      next_r.done_flag = 1'b1;
      next_r.mgstat = array_mgstat;
      if (code == CMD_KEY_VERIFY) begin
        if (key_match) next_r.security_state = SECURITY_OPEN_CODE;
        else next_r.key_locked = 1'b1;
      end
      if ((is_verify_all(code) || code == CMD_UNSECURE) && verify_erased && special_mode) begin
        next_r.security_state = SECURITY_OPEN_CODE;
        next_r.debug_enabled = 1'b1;
      end
    end

    // ECC faults on reads; a set wins over a clear in the same cycle
    if (read_valid) begin
      if (ecc_double || r.fdfd) next_r.double_fault_flag = 1'b1;
      if ((ecc_single && !r.ignsf) || r.fsfd) next_r.single_fault_flag = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.bus <= BUS_IDLE;
      r.done_flag <= 1'b1;
      r.protection <= RST_PROTECTION;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout = (r.bus != BUS_WAIT);
  assign hrdata = {24'h000000, r.rdata};
  assign hresp = 1'b0;
  assign cmd_start = r.cmd_start;
  assign command_parameters = r.params;
  // Scope stays valid for the whole command
  assign verify_all_blocks = !r.done_flag && is_verify_all(code);
  assign verify_eeprom_only = !r.done_flag && (code == CMD_VERIFY_EEPROM);
  assign program_protection = r.protection;
  assign clock_divider = r.divider;
  assign unsecured = (r.security_state == SECURITY_OPEN_CODE);
  assign debug_enabled = r.debug_enabled;
  assign security_area_open = unsecured;
  // Levels, no edge memory: they drop when flag or enable drops
  assign cmd_irq = r.done_flag && r.done_irq_en;
  assign err_irq = (r.double_fault_flag && r.double_fault_irq_enable) || (r.single_fault_flag && r.single_fault_irq_enable);

endmodule : flash_interrupt_security_ctrl
`default_nettype wire

/* verilog/flash_ctrl_pkg.sv */
`default_nettype none
package flash_ctrl_pkg;

  // ==========================================================
  // Register indices (byte address = 4 * index)
  localparam logic [4:0] IDX_CLOCK_DIVIDER = 5'h00;
  localparam logic [4:0] IDX_SECURITY_CONFIG = 5'h01;
  localparam logic [4:0] IDX_COMMAND_PARAM_INDEX = 5'h02;
  localparam logic [4:0] IDX_RESERVED_ZERO = 5'h03;
  localparam logic [4:0] IDX_MODULE_CONFIG = 5'h04;
  localparam logic [4:0] IDX_ERROR_INTERRUPT_CONFIG = 5'h05;
  localparam logic [4:0] IDX_COMMAND_STATUS = 5'h06;
  localparam logic [4:0] IDX_ERROR_STATUS = 5'h07;
  localparam logic [4:0] IDX_PROGRAM_PROTECTION = 5'h08;
  localparam logic [4:0] IDX_PARAM_HIGH = 5'h0A;
  localparam logic [4:0] IDX_PARAM_LOW = 5'h0B;
  localparam logic [4:0] IDX_LAST = 5'h13;

  // ==========================================================
  // Field positions
  localparam int DIV_LOADED_BIT = 7;
  localparam int DIV_LOCK_BIT = 6;
  localparam int DONE_IRQ_EN_BIT = 7;
  localparam int IGNSF_BIT = 4;
  localparam int FDFD_BIT = 1;
  localparam int FSFD_BIT = 0;
  localparam int DONE_FLAG_BIT = 7;
  localparam int ACCESS_ERR_BIT = 5;
  localparam int FPVIOL_BIT = 4;
  localparam int DOUBLE_BIT = 1;
  localparam int SINGLE_BIT = 0;

  // ==========================================================
  // Reset values and codes
  localparam logic [7:0] RST_PROTECTION = 8'hFF;
  localparam logic [1:0] SECURITY_OPEN_CODE = 2'h2;
  localparam logic [1:0] KEY_ACCESS_ON = 2'h2;
  localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
  localparam logic [7:0] CMD_VERIFY_EEPROM = 8'h02;
  localparam logic [7:0] CMD_PROG_FIRST = 8'h06;
  localparam logic [7:0] CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] CMD_KEY_VERIFY = 8'h0C;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} bus_state_t;

  // Complete state of the controller
  typedef struct packed {
    bus_state_t bus;
    logic bus_write;
    logic [4:0] bus_index;
    logic [7:0] rdata;
    logic [5:0] divider;
    logic div_lock;
    logic div_loaded;
    logic sec_loaded;
    logic [1:0] key_enable;
    logic [3:0] sec_reserved;
    logic [1:0] security_state;
    logic key_locked;
    logic debug_enabled;
    logic [2:0] param_index;
    logic [7:0][15:0] params;
    logic done_irq_en;
    logic ignsf;
    logic fdfd;
    logic fsfd;
    logic double_fault_irq_enable;
    logic single_fault_irq_enable;
    logic done_flag;
    logic access_err;
    logic fpviol;
    logic [1:0] mgstat;
    logic double_fault_flag;
    logic single_fault_flag;
    logic [7:0] protection;
    logic cmd_start;
  } ctrl_state_t;

endpackage : flash_ctrl_pkg
`default_nettype wire

/* test/flash_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// Bus timing and interrupt checks
module flash_ctrl_properties
  import flash_ctrl_pkg::*;
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Type
  input wire logic hwrite, // Write
  input wire logic hready, // Ready in
  input wire logic hreadyout, // Ready out
  input wire logic read_valid, // Array read
  input wire logic cmd_done, // Array done
  input wire logic cmd_start, // Launch
  input wire logic verify_all_blocks, // Scope all
  input wire logic verify_eeprom_only, // Scope EEPROM
  input wire logic [7:0][15:0] command_parameters, // Params
  input wire logic [7:0] program_protection, // Protection
  input wire logic unsecured, // Live state
  input wire logic debug_enabled, // Debug open
  input wire logic cmd_irq, // Command irq
  input wire logic err_irq // Error irq
);
  logic take;
  logic [7:0] code;
  // Taken address phase; its write lands two edges later
  assign take = hsel && htrans[1] && hready;
  assign code = command_parameters[0][15:8];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take;
    take;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_one_wait: assert property (s_take |=> s_wait)
    else $error("bus wait wrong");
  a_busy_quiet: assert property (cmd_start |-> !cmd_irq ##1 !cmd_start)
    else $error("irq during launch");
  a_scope_all: assert property (verify_all_blocks |-> code == CMD_VERIFY_ALL)
    else $error("scope all code");
  a_scope_ee: assert property (verify_eeprom_only |-> code == CMD_VERIFY_EEPROM)
    else $error("scope eeprom code");
  a_irq_rise: assert property ($rose(cmd_irq) |-> $past(cmd_done) || $past(take, 2))
    else $error("cmd irq cause");
  a_err_rise: assert property ($rose(err_irq) |-> $past(read_valid) || $past(take, 2))
    else $error("err irq cause");
  a_err_fall: assert property ($fell(err_irq) |-> $past(take, 2))
    else $error("err irq dropped");
  a_prot_keep: assert property (!$stable(program_protection) |-> $past(take && hwrite, 2))
    else $error("protection changed");
  a_unsec_keep: assert property (unsecured |=> unsecured)
    else $error("security relocked");
  a_debug_keep: assert property (debug_enabled |=> debug_enabled)
    else $error("debug closed");
endmodule : flash_ctrl_properties
`default_nettype wire

/* test/flash_far_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// Flash array stand-in
module flash_far_side_model (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic cmd_start, // Launch
  input wire logic [7:0] delay, // Busy cycles
  input wire logic erased_set, // Verify result
  input wire logic match_set, // Key result
  output logic cmd_done, // Done pulse
  output logic verify_erased, // Valid at done
  output logic key_match, // Valid at done
  output logic [1:0] array_mgstat // Valid at done
);
  logic [7:0] cnt;
  logic junk;
  // Countdown; junk toggles so stale results never look valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h00;
      junk <= 1'b0;
    end else begin
      junk <= ~junk;
      if (cmd_start) begin
        cnt <= delay;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
  // Results hold meaning only on the done cycle
  assign cmd_done = (cnt == 8'h01);
  assign verify_erased = cmd_done ? erased_set : junk;
  assign key_match = cmd_done ? match_set : junk;
  assign array_mgstat = cmd_done ? 2'h0 : {junk, ~junk};
endmodule : flash_far_side_model
`default_nettype wire

/* test/flash_interrupt_security_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// Register, command and security scenarios
module flash_interrupt_security_ctrl_tb_top;
  import flash_ctrl_pkg::*;
  logic hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp, cmd_done;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, array_mgstat;
  logic [2:0] hsize;
  logic [7:0] nv_security, program_protection, delay, r;
  logic special_mode, verify_erased, key_match, read_valid, ecc_single, ecc_double;
  logic cmd_start, verify_all_blocks, verify_eeprom_only, unsecured, debug_enabled;
  logic security_area_open, cmd_irq, err_irq, erased_set, match_set;
  logic [7:0][15:0] command_parameters;
  logic [5:0] clock_divider;
  int err_count = 0;
  int samples_checked = 0;
  int starts = 0;
  int cycles = 0;
  assign hready = hreadyout;
  flash_interrupt_security_ctrl i_dut (.*);
  flash_far_side_model i_far (.*);
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Launch counter and hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cmd_start === 1'b1) starts++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Single word transfer; waits on the slave, only the guard ends a hang
  task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {25'h0000000, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask : bus
  task automatic launch(input logic [7:0] code);
    bus(1'b1, IDX_COMMAND_PARAM_INDEX, 8'h00);
    bus(1'b1, IDX_PARAM_HIGH, code);
    bus(1'b1, IDX_COMMAND_STATUS, 8'h80);
    repeat (2) @(posedge hclk);
  endtask : launch
  task automatic wait_done();
    do @(posedge hclk); while (cmd_done !== 1'b1);
    @(posedge hclk);
  endtask : wait_done
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset
  task automatic t_regs();
    bus(1'b0, IDX_COMMAND_STATUS, 8'h00);
    chk(r, 8'h80, "status reset");
    bus(1'b0, IDX_PROGRAM_PROTECTION, 8'h00);
    chk(r, RST_PROTECTION, "protection reset");
    chk({7'h00, hresp}, 8'h00, "okay resp");
    bus(1'b1, IDX_RESERVED_ZERO, 8'hFF);
    bus(1'b0, IDX_RESERVED_ZERO, 8'h00);
    chk(r, 8'h00, "reserved");
    bus(1'b0, 5'h14, 8'h00);
    chk(r, 8'h00, "unmapped");
    bus(1'b0, IDX_SECURITY_CONFIG, 8'h00);
    chk(r, nv_security, "security copy");
  endtask : t_regs
  task automatic t_divider();
    launch(CMD_PROG_FIRST);
    bus(1'b0, IDX_COMMAND_STATUS, 8'h00);
    chk(r, 8'hA0, "no divider");
    chk(8'(starts), 8'h00, "no launch");
    bus(1'b1, IDX_COMMAND_STATUS, 8'h20);
    bus(1'b1, IDX_CLOCK_DIVIDER, 8'h13);
    bus(1'b0, IDX_CLOCK_DIVIDER, 8'h00);
    chk(r, 8'h93, "divider loaded");
    chk({2'h0, clock_divider}, 8'h13, "divider out");
  endtask : t_divider
  task automatic t_verify(input logic [7:0] code);
    delay <= 8'h40;
    bus(1'b1, IDX_MODULE_CONFIG, 8'h80);
    launch(code);
    chk({7'h00, verify_all_blocks}, {7'h00, code == CMD_VERIFY_ALL}, "all");
    chk({7'h00, verify_eeprom_only}, {7'h00, code == CMD_VERIFY_EEPROM}, "eeprom");
    bus(1'b1, IDX_PARAM_HIGH, 8'h55);
    chk(command_parameters[0][15:8], code, "busy write");
    chk({7'h00, cmd_irq}, 8'h00, "irq busy");
    wait_done();
    chk({7'h00, cmd_irq}, 8'h01, "irq done");
    bus(1'b1, IDX_MODULE_CONFIG, 8'h00);
    chk({7'h00, cmd_irq}, 8'h00, "irq masked");
  endtask : t_verify
  // Wrong enable first, then the right one while the flag still holds
  task automatic t_ecc();
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, IDX_ERROR_INTERRUPT_CONFIG, (i == 0) ? 8'h01 : 8'h02);
      read_valid <= 1'b1;
      ecc_double <= (i == 0);
      ecc_single <= (i == 1);
      @(posedge hclk);
      read_valid <= 1'b0;
      @(posedge hclk);
      chk({7'h00, err_irq}, 8'h00, "fault masked");
      bus(1'b1, IDX_ERROR_INTERRUPT_CONFIG, 8'h03);
      chk({7'h00, err_irq}, 8'h01, "fault irq");
      bus(1'b1, IDX_ERROR_STATUS, (i == 0) ? 8'h02 : 8'h01);
      chk({7'h00, err_irq}, 8'h00, "fault clear");
    end
  endtask : t_ecc
  task automatic t_key();
    // Long enough that the done pulse comes after launch returns
    delay <= 8'h10;
    launch(CMD_KEY_VERIFY);
    wait_done();
    chk({7'h00, unsecured}, 8'h00, "bad key");
    launch(CMD_KEY_VERIFY);
    bus(1'b0, IDX_COMMAND_STATUS, 8'h00);
    chk(r & 8'hA0, 8'hA0, "key refused");
    match_set <= 1'b1;
    do_reset();
    launch(CMD_KEY_VERIFY);
    wait_done();
    chk({6'h00, unsecured, security_area_open}, 8'h03, "key ok");
    bus(1'b0, IDX_SECURITY_CONFIG, 8'h00);
    chk(r, {nv_security[7:2], SECURITY_OPEN_CODE}, "live state");
    chk(program_protection, RST_PROTECTION, "protection kept");
  endtask : t_key
  task automatic t_debug();
    special_mode <= 1'b1;
    nv_security <= 8'h00;
    erased_set <= 1'b1;
    do_reset();
    launch(CMD_VERIFY_ALL);
    wait_done();
    chk({6'h00, unsecured, debug_enabled}, 8'h03, "debug open");
  endtask : t_debug
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    {hsel, hwrite, read_valid, ecc_single, ecc_double, special_mode, erased_set, match_set} = 8'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    clk_en = 1'b1;
    hresetn = 1'b0;
    nv_security = 8'h80;
    delay = 8'h10;
    do_reset();
    t_regs();
    t_divider();
    t_verify(CMD_VERIFY_ALL);
    t_verify(CMD_VERIFY_EEPROM);
    t_ecc();
    t_key();
    t_debug();
    tally_and_finish();
  end
endmodule : flash_interrupt_security_ctrl_tb_top
bind flash_interrupt_security_ctrl flash_ctrl_properties u_props (.*);
`default_nettype wire
